// >>> rtl/hbid_top.sv
// Behaviour
// - peak weight bits 13:12, weights 2..16, default 8
// - peak average weighted recurrence per peak
// - threshold is average times (scale+1)/16
// - static hold-off bits 21:16, reset 32
// - static hold-off times eight ms unit
// - hold-off is max of static, dynamic
// - interval weight bits 13:12, default 8
// - interval average weighted recurrence per beat
// - dynamic hold-off is average times scale/8
// - scale zero means static hold-off only
// - runs only with both enables set
// - beat loads left-justified interval, sets flag
// - interval counter wraps silently
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module hbid_top
  import hbid_pkg::*;
#(
  parameter int SW         = 16,
  parameter int UNIT_CYCLES = HBID_UNIT_CYCLES
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire logic          i_channel_enable,
  input  wire logic          i_sample_valid,
  input  wire logic [SW-1:0] i_sample,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               o_irq
);

  if (SW < 4 || SW > 20) begin : g_bad_width
    $error("hbid_top: unsupported sample width");
  end
  if (UNIT_CYCLES < 1 || UNIT_CYCLES > 16777215) begin : g_bad_unit
    $error("hbid_top: unsupported unit length");
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic        beat_detect_enable_reg;
  logic [1:0]  peak_avg_weight_reg;
  logic [3:0]  peak_threshold_scale_reg;
  logic [5:0]  min_holdoff_reg;
  logic [1:0]  interval_avg_weight_reg;
  logic [2:0]  dynamic_holdoff_scale_reg;
  logic [13:0] beat_interval_result_reg;
  logic        beat_interrupt_flag_reg;
  logic        beat_int_en_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        irq_reg;

  wire        setup      = psel & ~penable;
  wire [9:0]  word_idx   = paddr[11:2];
  wire        hit_gain   = word_idx == {2'h0, HBID_IDX_GAIN_THRESH};
  wire        hit_timing = word_idx == {2'h0, HBID_IDX_TIMING};
  wire        hit_result = word_idx == {2'h0, HBID_IDX_RESULT};
  wire        hit_ctrl   = word_idx == {2'h0, HBID_IDX_CTRL};
  wire        hit_status = word_idx == {2'h0, HBID_IDX_STATUS};
  wire        hit_clr    = word_idx == {2'h0, HBID_IDX_INT_CLR};
  wire        hit_en     = word_idx == {2'h0, HBID_IDX_INT_EN};
  wire        mapped     = hit_gain | hit_timing | hit_result | hit_ctrl |
                           hit_status | hit_clr | hit_en;
  // Writes land at the edge that ends the access phase
  wire        do_write   = psel & penable & pready_reg & pwrite & mapped;
  wire        wr_gain    = do_write & hit_gain;
  wire        wr_timing  = do_write & hit_timing;
  wire        wr_clr     = do_write & hit_clr & pwdata[0];
  wire        wr_en      = do_write & hit_en;

  wire [31:0] rd_gain = {16'h0, beat_detect_enable_reg, 1'b0,
                         peak_avg_weight_reg, peak_threshold_scale_reg, 8'h0};
  wire [31:0] rd_timing = {10'h0, min_holdoff_reg, 2'h0,
                           interval_avg_weight_reg, 1'b0,
                           dynamic_holdoff_scale_reg, 8'h0};
  wire [31:0] rd_result = {8'h0, beat_interval_result_reg, 10'h0};
  wire [31:0] rd_word =
    hit_gain   ? rd_gain :
    hit_timing ? rd_timing :
    hit_result ? rd_result :
    hit_status ? {31'h0, beat_interrupt_flag_reg} :
    hit_en     ? {31'h0, beat_int_en_reg} : 32'h0;

  // Slave answers in the access cycle: one wait-free access phase
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      prdata_reg  <= (setup & ~pwrite) ? rd_word : 32'h0;
    end
  end

  // peak weight and threshold scale fields
  // scale field reset to four sixteenths
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      beat_detect_enable_reg   <= 1'b0;
      peak_avg_weight_reg      <= HBID_PAVG_RST;
      peak_threshold_scale_reg <= HBID_PTSF_RST;
    end else if (wr_gain) begin
      beat_detect_enable_reg   <= pwdata[HBID_EN_POS];
      peak_avg_weight_reg      <= pwdata[HBID_PAVG_LSB +: 2];
      peak_threshold_scale_reg <= pwdata[HBID_PTSF_LSB +: 4];
    end
  end

  // interval weight field, reset code 2
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      min_holdoff_reg           <= HBID_HOFF_RST;
      interval_avg_weight_reg   <= HBID_RAVG_RST;
      dynamic_holdoff_scale_reg <= HBID_RHSF_RST;
    end else if (wr_timing) begin
      min_holdoff_reg           <= pwdata[HBID_HOFF_LSB +: 6];
      interval_avg_weight_reg   <= pwdata[HBID_RAVG_LSB +: 2];
      dynamic_holdoff_scale_reg <= pwdata[HBID_RHSF_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------------
  // Time base and interval counter
  // ----------------------------------------------------------------------
  logic [23:0] tick_cnt_reg;
  logic [13:0] interval_cnt_reg;
  logic        beat;

  // detector active only with both enables
  wire active   = beat_detect_enable_reg & i_channel_enable;
  wire tick     = tick_cnt_reg == 24'(UNIT_CYCLES - 1);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !active || tick) begin
      tick_cnt_reg <= 24'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !active) begin
      interval_cnt_reg <= 14'h0;
    end else if (beat) begin
      interval_cnt_reg <= 14'(tick);
    end else if (tick) begin
      interval_cnt_reg <= interval_cnt_reg + 14'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Running averages
  // ----------------------------------------------------------------------
  hbid_avg_if #(.W(SW)) peak_if ();
  hbid_avg_if #(.W(14)) ivl_if ();

  logic [SW-1:0] peak_max_reg;

  // averages move only on accepted beats
  assign peak_if.update      = beat;
  assign peak_if.weight_code = peak_avg_weight_reg;
  assign peak_if.sample      = peak_max_reg;
  assign ivl_if.update       = beat;
  assign ivl_if.weight_code  = interval_avg_weight_reg;
  assign ivl_if.sample       = interval_cnt_reg;

  hbid_avg #(.W(SW)) u_peak_avg (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .bus       (peak_if.avg)
  );

  hbid_avg #(.W(14)) u_ivl_avg (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .bus       (ivl_if.avg)
  );

  wire [SW+3:0] thr_prod  = (SW+4)'(peak_if.average) *
                            (SW+4)'({1'b0, peak_threshold_scale_reg} + 5'h1);
  wire [SW-1:0] threshold = SW'(thr_prod >> 4);

  // zero scale yields no dynamic part
  wire [16:0] dyn_prod = 17'(ivl_if.average) *
                         17'(dynamic_holdoff_scale_reg);
  wire [13:0] dyn_holdoff = 14'(dyn_prod >> 3);
  // static part counted in detector units
  wire [13:0] static_holdoff = {8'h0, min_holdoff_reg};
  wire [13:0] holdoff = (dyn_holdoff > static_holdoff) ? dyn_holdoff
                                                       : static_holdoff;
  wire        holdoff_done = interval_cnt_reg >= holdoff;

  // ----------------------------------------------------------------------
  // Beat qualification
  // ----------------------------------------------------------------------
  hbid_state_t state_reg;
  hbid_state_t state_next;

  wire above = i_sample_valid & (i_sample > threshold);
  wire below = i_sample_valid & ~(i_sample > threshold);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HBID_IDLE:  state_next = HBID_ARMED;
      HBID_ARMED: if (above && holdoff_done) begin
        state_next = HBID_PEAK;
      end
      HBID_PEAK:  if (below) begin
        state_next = HBID_ARMED;
      end
      default:    state_next = HBID_IDLE;
    endcase
    if (!active) begin
      state_next = HBID_IDLE;
    end
  end

  assign beat = active && state_reg == HBID_PEAK && below;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= HBID_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Peak tracking within an excursion
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || state_reg != HBID_PEAK) begin
      peak_max_reg <= (state_next == HBID_PEAK) ? i_sample : '0;
    end else if (i_sample_valid && i_sample > peak_max_reg) begin
      peak_max_reg <= i_sample;
    end
  end

  // ----------------------------------------------------------------------
  // Result and interrupt
  // ----------------------------------------------------------------------
  // load interval result on each beat
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      beat_interval_result_reg <= 14'h0;
    end else if (beat) begin
      beat_interval_result_reg <= interval_cnt_reg;
    end
  end

  // set beats clear in same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      beat_interrupt_flag_reg <= 1'b0;
    end else if (beat) begin
      beat_interrupt_flag_reg <= 1'b1;
    end else if (wr_clr) begin
      beat_interrupt_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      beat_int_en_reg <= 1'b0;
      irq_reg         <= 1'b0;
    end else begin
      if (wr_en) begin
        beat_int_en_reg <= pwdata[0];
      end
      irq_reg <= beat_interrupt_flag_reg & beat_int_en_reg;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign o_irq   = irq_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // no beat without both enables
  beat_needs_enable_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset) beat |-> beat_detect_enable_reg && i_channel_enable)
    else $error("beat while disabled");

  result_load_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    beat |=> beat_interval_result_reg == $past(interval_cnt_reg)
             && beat_interrupt_flag_reg) else $error("result not loaded");

  holdoff_gate_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    (state_reg == HBID_ARMED && state_next == HBID_PEAK) |->
      interval_cnt_reg >= {8'h0, min_holdoff_reg}) else
    $error("entry inside hold-off");

  static_only_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    dynamic_holdoff_scale_reg == 3'h0 |-> holdoff == static_holdoff) else
    $error("dynamic part with zero scale");

  counter_wrap_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    (active && tick && !beat && interval_cnt_reg == 14'h3fff) |=>
      interval_cnt_reg == 14'h0 || !$past(active)) else
    $error("counter did not wrap");

  hoff_reset_a: assert property (@(posedge i_sys_clk)
    $past(i_reset) |-> min_holdoff_reg == 6'h20 &&
      interval_avg_weight_reg == 2'h2 && peak_avg_weight_reg == 2'h2) else
    $error("reset defaults wrong");

  thr_bound_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    threshold <= peak_if.average) else $error("threshold too large");

  holdoff_max_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    holdoff >= static_holdoff && holdoff >= dyn_holdoff &&
    (holdoff == static_holdoff || holdoff == dyn_holdoff)) else
    $error("hold-off not maximum");

  irq_level_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    ##1 o_irq == $past(beat_interrupt_flag_reg && beat_int_en_reg)) else
    $error("irq mismatch");

endmodule
`default_nettype wire

// >>> rtl/hbid_pkg.sv
`default_nettype none
package hbid_pkg;

  // ----------------------------------------------------------------------
  // Register indices (printed offsets are not word multiples)
  // ----------------------------------------------------------------------
  localparam logic [7:0] HBID_IDX_GAIN_THRESH = 8'h1d;
  localparam logic [7:0] HBID_IDX_TIMING      = 8'h1e;
  localparam logic [7:0] HBID_IDX_RESULT      = 8'h1f;
  localparam logic [7:0] HBID_IDX_CTRL        = 8'h20;
  localparam logic [7:0] HBID_IDX_STATUS      = 8'h21;
  localparam logic [7:0] HBID_IDX_INT_CLR     = 8'h22;
  localparam logic [7:0] HBID_IDX_INT_EN      = 8'h23;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int HBID_EN_POS        = 15;
  localparam int HBID_PAVG_LSB      = 12;
  localparam int HBID_PTSF_LSB      = 8;
  localparam int HBID_HOFF_LSB      = 16;
  localparam int HBID_RAVG_LSB      = 12;
  localparam int HBID_RHSF_LSB      = 8;
  localparam int HBID_RESULT_LSB    = 10;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] HBID_PAVG_RST = 2'h2;
  localparam logic [3:0] HBID_PTSF_RST = 4'h3;
  localparam logic [5:0] HBID_HOFF_RST = 6'h20;
  localparam logic [1:0] HBID_RAVG_RST = 2'h2;
  localparam logic [2:0] HBID_RHSF_RST = 3'h4;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int HBID_CLK_HZ      = 10_000_000;
  localparam int HBID_UNIT_US     = 8000;
  localparam int HBID_UNIT_CYCLES = HBID_CLK_HZ / 1_000_000 * HBID_UNIT_US;

  typedef enum logic [1:0] {
    HBID_IDLE,
    HBID_ARMED,
    HBID_PEAK
  } hbid_state_t;

endpackage
`default_nettype wire

// >>> rtl/hbid_avg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hbid_avg_if #(parameter int W = 16);
  logic         update;
  logic [1:0]   weight_code;
  logic [W-1:0] sample;
  logic [W-1:0] average;
  modport owner (output update, output weight_code, output sample,
                 input average);
  modport avg   (input update, input weight_code, input sample,
                 output average);
endinterface
`default_nettype wire

// >>> rtl/hbid_avg.sv
`timescale 1ns/10ps
`default_nettype none
module hbid_avg
  import hbid_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  hbid_avg_if.avg   bus
);

  if (W < 2 || W > 24) begin : g_bad_width
    $error("hbid_avg: unsupported width");
  end

  logic [W-1:0] avg_reg;
  logic [W+4:0] prod;
  logic [W+4:0] sum;
  logic [W-1:0] avg_next;
  logic [2:0]   shift;
  logic [4:0]   weight;

  assign shift  = {1'b0, bus.weight_code} + 3'h1;
  assign weight = 5'h1 << shift;
  assign prod   = (W+5)'(avg_reg) * (W+5)'(weight - 5'h1);
  assign sum    = prod + (W+5)'(bus.sample);
  assign avg_next = W'(sum >> shift);
  assign bus.average = avg_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      avg_reg <= '0;
    end else if (bus.update) begin
      avg_reg <= avg_next;
    end
  end

  avg_step_a: assert property (@(posedge i_sys_clk)
    disable iff (i_reset)
    bus.update |=> avg_reg == $past(avg_next)) else
    $error("average step wrong");

endmodule
`default_nettype wire

// >>> test/hbid_sample_src.sv
`timescale 1ns/10ps
`default_nettype none
module hbid_sample_src #(
  parameter int SW = 16
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire logic [SW-1:0] i_level,
  output logic               o_sample_valid,
  output logic      [SW-1:0] o_sample
);
  // ----------------------------------------------------------------------
  // Filter output, one sample every second cycle
  // ----------------------------------------------------------------------
  logic gap_reg;

  // Off-strobe cycles show the inverse, never a stale valid-looking value
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      gap_reg        <= 1'b0;
      o_sample_valid <= 1'b0;
      o_sample       <= '0;
    end else if (gap_reg) begin
      gap_reg        <= 1'b0;
      o_sample_valid <= 1'b1;
      o_sample       <= i_level;
    end else begin
      gap_reg        <= 1'b1;
      o_sample_valid <= 1'b0;
      o_sample       <= ~o_sample;
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_heartbeat_interval_detector.sv
`timescale 1ns/10ps
`default_nettype none
module tb_heartbeat_interval_detector
  import hbid_pkg::*;
;
  localparam int UC = 4;
  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
    logic        err;
  } hbid_note_t;

  logic        i_sys_clk, i_reset, ch_en, psel, penable, pwrite;
  logic        pready, pslverr, o_irq, s_vld;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, rng, v;
  logic [15:0] level, s_dat, amp;
  int          mismatches = 0, num_checks = 0, cyc = 0, t_ref, t_fall;
  hbid_note_t  notes[$];
  hbid_note_t  nt;

  hbid_top #(.UNIT_CYCLES(UC)) dut_u (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_channel_enable(ch_en),
    .i_sample_valid(s_vld), .i_sample(s_dat), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_irq(o_irq));

  hbid_sample_src src_u (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_level(level),
    .o_sample_valid(s_vld), .o_sample(s_dat));

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Oldest note is matched against every completed transfer
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      check("prdata", prdata & nt.msk, nt.exp & nt.msk);
      check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
    end else if (pready === 1'b1) begin
      check("pready", 32'h1, 32'h0);
    end
    if (cyc == 85000) begin
      mismatches++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, input logic [31:0] exp,
                     input logic [31:0] msk);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    notes.push_back('{exp, msk,
      (idx < HBID_IDX_GAIN_THRESH) || (idx > HBID_IDX_INT_EN)});
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e,
                    input logic [31:0] m);
    apb(1'b0, idx, 32'h0, e, m);
  endtask

  task automatic st(input logic b);
    rd(HBID_IDX_STATUS, {31'h0, b}, 32'h1);
  endtask

  task automatic pulse(input int at, input logic [15:0] a);
    while (cyc < t_ref + at) @(posedge i_sys_clk);
    level <= a;
    repeat (8) @(posedge i_sys_clk);
    level <= 16'h0;
    t_fall = cyc;
    repeat (8) @(posedge i_sys_clk);
  endtask

  task automatic interval(input int lo, input int hi);
    rd(HBID_IDX_RESULT, 32'h0, 32'hff00_03ff);
    check("interval", {31'h0, rdat[23:10] >= lo && rdat[23:10] <= hi},
          32'h1);
  endtask

  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    i_reset <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_reset = 1'b1;
    ch_en = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    level = 16'h0;
    t_ref = 0;
    rng = 32'h0001_3b43;
    do_reset();
    rd(HBID_IDX_GAIN_THRESH, 32'h0000_2300, 32'h0000_bf00);
    rd(HBID_IDX_TIMING, 32'h0020_2400, 32'h003f_3700);
    rd(HBID_IDX_RESULT, 32'h0, 32'hffff_ffff);
    st(1'b0);
    rd(HBID_IDX_INT_EN, 32'h0, 32'h1);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    wr(8'h40, 32'hffff_ffff);
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      v = (rng & 32'h003f_8f00) | (k << 12);
      wr(HBID_IDX_GAIN_THRESH, v);
      wr(HBID_IDX_TIMING, v);
      wr(HBID_IDX_INT_EN, v);
      rd(HBID_IDX_GAIN_THRESH, v, 32'h0000_bf00);
      rd(HBID_IDX_TIMING, v, 32'h003f_3700);
      rd(HBID_IDX_INT_EN, v, 32'h1);
    end
    // Enables, static hold-off, interrupt, wrap
    do_reset();
    amp = 16'h0400 | rng[9:0];
    wr(HBID_IDX_INT_EN, 32'h1);
    ch_en <= 1'b1;
    t_ref = cyc;
    pulse(150, amp);
    st(1'b0);
    wr(HBID_IDX_GAIN_THRESH, 32'h0000_a300);
    ch_en <= 1'b0;
    t_ref = cyc;
    pulse(150, amp);
    st(1'b0);
    ch_en <= 1'b1;
    t_ref = cyc;
    pulse(150, amp);
    st(1'b1);
    check("irq", {31'h0, o_irq}, 32'h1);
    wr(HBID_IDX_INT_CLR, 32'h1);
    st(1'b0);
    check("irq", {31'h0, o_irq}, 32'h0);
    t_ref = t_fall;
    pulse(110, amp);
    st(1'b0);
    pulse(140, amp);
    st(1'b1);
    interval(36, 38);
    wr(HBID_IDX_INT_EN, 32'h0);
    wr(HBID_IDX_INT_CLR, 32'h1);
    t_ref = t_fall;
    pulse(140, amp);
    st(1'b1);
    check("irq", {31'h0, o_irq}, 32'h0);
    t_ref = t_fall;
    pulse((16384 + 40) * UC, amp);
    interval(41, 43);
    // Averaging, dynamic hold-off and threshold scaling
    do_reset();
    wr(HBID_IDX_GAIN_THRESH, 32'h0000_8f00);
    wr(HBID_IDX_TIMING, 32'h0001_0700);
    t_ref = cyc;
    for (int k = 0; k < 3; k++) begin
      pulse(140, 16'h03e8);
      t_ref = t_fall;
    end
    wr(HBID_IDX_INT_CLR, 32'h1);
    pulse(40, 16'h03e8);
    st(1'b0);
    wr(HBID_IDX_TIMING, 32'h0001_0000);
    pulse(70, 16'h03e8);
    st(1'b1);
    wr(HBID_IDX_INT_CLR, 32'h1);
    t_ref = t_fall;
    pulse(140, 16'h0384);
    st(1'b0);
    pulse(180, 16'h03c0);
    st(1'b1);
    summarize();
  end
endmodule
`default_nettype wire
